// file: rtl/vdms_defines.svh
`ifndef VDMS_DEFINES_SVH
`define VDMS_DEFINES_SVH

// ==========================================================
// register subaddresses
`define VDMS_ADDR_MISC      8'h17
`define VDMS_ADDR_RAW_GAIN  8'h18
`define VDMS_ADDR_RAW_OFS   8'h19
`define VDMS_ADDR_STAT1     8'h1E
`define VDMS_ADDR_STAT2     8'h1F

// ==========================================================
// misc register fields
`define VDMS_MISC_LINE_TRI  7
`define VDMS_MISC_HALF_TRI  6
`define VDMS_MISC_LAT_HI    5
`define VDMS_MISC_LAT_LO    3
`define VDMS_MISC_ALT_POS   2
`define VDMS_MISC_STOP_MSB  1
`define VDMS_MISC_START_MSB 0

// ==========================================================
// status byte fields
`define VDMS_ST1_HUNLOCK    6
`define VDMS_ST1_SLOW       5
`define VDMS_ST1_GTOP       4
`define VDMS_ST1_GBOT       3
`define VDMS_ST1_WPEAK      2
`define VDMS_ST2_ILACE      7
`define VDMS_ST2_HVUNLOCK   6
`define VDMS_ST2_SIXTY      5
`define VDMS_ST2_STRIPE4    3
`define VDMS_ST2_STRIPE     2
`define VDMS_ST2_COPY       1
`define VDMS_ST2_READY      0

// ==========================================================
// reset values and constants
`define VDMS_MISC_RST       8'h18
`define VDMS_GAIN_RST       8'h40
`define VDMS_OFS_RST        8'h80
`define VDMS_LAT_RESERVED   3'h0
`define VDMS_LAT_DEFAULT    3'h3
`define VDMS_GAIN_SHIFT     6
`define VDMS_OFS_ZERO       12'sh080
`define VDMS_PIX_MAX        12'sh0FF

`endif

// file: rtl/vdms_pkg.sv
package vdms_pkg;

    // nine-bit line number within a field
    typedef logic [8:0] vdms_line_type;

    // vertical gate states
    typedef enum logic {
        GATE_LOW,
        GATE_HIGH
    } vdms_gate_state_type;

endpackage

// file: rtl/vdms_gate_gen.sv
`timescale 1ns/1ps
`include "vdms_defines.svh"

module vdms_gate_gen (
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    input  wire logic                   line_start_i,
    input  wire logic                   second_field_i,
    input  wire vdms_pkg::vdms_line_type line_count_i,
    input  wire vdms_pkg::vdms_line_type start_line_i,
    input  wire vdms_pkg::vdms_line_type stop_line_i,
    input  wire logic                   alt_pos_i,
    output logic                        vertical_gate_o,
    output logic                        field_identifier_o
);

    vdms_pkg::vdms_gate_state_type state_r;
    vdms_pkg::vdms_line_type       start_eff;
    vdms_pkg::vdms_line_type       stop_eff;
    logic                          hit_start;
    logic                          hit_stop;

    // ==========================================================
    // effective lines
    // one line earlier in field two when alt_pos_i is set
    always_comb begin
        start_eff = start_line_i;
        stop_eff  = stop_line_i;
        if (alt_pos_i && second_field_i) begin
            start_eff = start_line_i - 9'h001;
            stop_eff  = stop_line_i - 9'h001;
        end
    end

    assign hit_start = line_start_i && (line_count_i == start_eff);
    assign hit_stop  = line_start_i && (line_count_i == stop_eff);

    // ==========================================================
    // gate state, start wins over stop
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= vdms_pkg::GATE_LOW;
        end else if (ce_i) begin
            unique case (state_r)
                vdms_pkg::GATE_LOW: begin
                    if (hit_start) begin
                        state_r <= vdms_pkg::GATE_HIGH;
                    end
                end
                vdms_pkg::GATE_HIGH: begin
                    if (hit_stop && !hit_start) begin
                        state_r <= vdms_pkg::GATE_LOW;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // field identifier flips at the start line
    // polarity change
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            field_identifier_o <= 1'b0;
        end else if (ce_i && hit_start) begin
            field_identifier_o <= ~field_identifier_o;
        end
    end

    assign vertical_gate_o = (state_r == vdms_pkg::GATE_HIGH);

endmodule

// file: rtl/vdms_regs.sv
`timescale 1ns/1ps
`include "vdms_defines.svh"

module vdms_regs (
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    // register port behind the serial control interface
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_rd_i,
    output logic [7:0]                   reg_rdata_o,
    output logic                         reg_rvalid_o,
    // clock outputs
    output logic                         line_locked_clock_out_o,
    output logic                         line_clock_out_oe_n_o,
    output logic                         half_rate_clock_out_o,
    output logic                         half_clock_out_oe_n_o,
    // standard detection search
    input  wire logic                    field_start_i,
    output logic                         search_period_o,
    // vertical gate
    input  wire logic                    line_start_i,
    input  wire logic                    second_field_i,
    input  wire vdms_pkg::vdms_line_type line_count_i,
    input  wire logic [7:0]              gate_start_low_i,
    input  wire logic [7:0]              gate_stop_low_i,
    output logic                         vertical_gate_o,
    output logic                         field_identifier_o,
    // raw sample path
    input  wire logic [7:0]              raw_sample_i,
    input  wire logic                    raw_valid_i,
    output logic [7:0]                   raw_sample_o,
    output logic                         raw_valid_o,
    // decoder status sources
    input  wire logic                    hloop_unlocked_i,
    input  wire logic                    vloop_unlocked_i,
    input  wire logic                    other_loops_locked_i,
    input  wire logic                    slow_constant_active_i,
    input  wire logic                    luma_gain_at_top_i,
    input  wire logic                    luma_gain_at_bottom_i,
    input  wire logic                    white_peak_active_i,
    input  wire logic [1:0]              colour_standard_found_i,
    input  wire logic                    interlace_seen_i,
    input  wire logic                    field_rate_sixty_i,
    input  wire logic                    stripe_four_line_seen_i,
    input  wire logic                    stripe_any_seen_i,
    input  wire logic                    protected_source_seen_i
);

    logic        rst_sync1_r;
    logic        rst_sync2_r;
    logic        rst_n;
    logic [7:0]  misc_clock_gate_msb_ctrl_r;
    logic [7:0]  raw_path_gain_r;
    logic [7:0]  raw_path_offset_r;
    logic [7:0]  decoder_status_first_r;
    logic [7:0]  decoder_status_second_r;
    logic [7:0]  status_first_nxt;
    logic [7:0]  status_second_nxt;
    logic [7:0]  rdata_nxt;
    logic [1:0]  clk_div_r;
    logic [2:0]  search_latency_fields;
    logic [2:0]  field_cnt_r;
    logic [15:0] raw_prod;
    logic signed [11:0] raw_sum;
    logic        hv_loops_unlocked;
    logic        capture_ready;
    vdms_pkg::vdms_line_type gate_start_line;
    vdms_pkg::vdms_line_type gate_stop_line;

    // ==========================================================
    // reset release through two flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    assign rst_n = rst_sync2_r;

    // ==========================================================
    // control register writes
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            misc_clock_gate_msb_ctrl_r <= `VDMS_MISC_RST;
            raw_path_gain_r            <= `VDMS_GAIN_RST;
            raw_path_offset_r          <= `VDMS_OFS_RST;
        end else if (ce_i && reg_wr_i) begin
            unique case (reg_addr_i)
                `VDMS_ADDR_MISC:     misc_clock_gate_msb_ctrl_r <= reg_wdata_i;
                `VDMS_ADDR_RAW_GAIN: raw_path_gain_r            <= reg_wdata_i;
                `VDMS_ADDR_RAW_OFS:  raw_path_offset_r          <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // status byte assembly
    // sources share this clock,
    // so no synchroniser is needed
    assign hv_loops_unlocked = hloop_unlocked_i | vloop_unlocked_i;
    assign capture_ready     = ~hv_loops_unlocked & other_loops_locked_i;

    always_comb begin
        status_first_nxt  = 8'h00;
        status_second_nxt = 8'h00;
        status_first_nxt[1:0]               = colour_standard_found_i;
        status_first_nxt[`VDMS_ST1_HUNLOCK] = hloop_unlocked_i;
        status_first_nxt[`VDMS_ST1_SLOW]    = slow_constant_active_i;
        status_first_nxt[`VDMS_ST1_GTOP]    = luma_gain_at_top_i;
        status_first_nxt[`VDMS_ST1_GBOT]    = luma_gain_at_bottom_i;
        status_first_nxt[`VDMS_ST1_WPEAK]   = white_peak_active_i;
        status_second_nxt[`VDMS_ST2_ILACE]    = interlace_seen_i;
        status_second_nxt[`VDMS_ST2_HVUNLOCK] = hv_loops_unlocked;
        status_second_nxt[`VDMS_ST2_SIXTY]    = field_rate_sixty_i;
        status_second_nxt[`VDMS_ST2_STRIPE4]  = stripe_four_line_seen_i;
        status_second_nxt[`VDMS_ST2_STRIPE]   = stripe_any_seen_i | stripe_four_line_seen_i;
        status_second_nxt[`VDMS_ST2_COPY]     = protected_source_seen_i;
        status_second_nxt[`VDMS_ST2_READY]    = capture_ready;
    end

    // ==========================================================
    // status snapshot, whole byte per edge
    // coherent status capture
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            decoder_status_first_r  <= 8'h00;
            decoder_status_second_r <= 8'h00;
        end else if (ce_i) begin
            decoder_status_first_r  <= status_first_nxt;
            decoder_status_second_r <= status_second_nxt;
        end
    end

    // ==========================================================
    // read mux, unmapped reads return zero
    // status reads see one whole
    // snapshot, never a torn byte
    always_comb begin
        unique case (reg_addr_i)
            `VDMS_ADDR_MISC:     rdata_nxt = misc_clock_gate_msb_ctrl_r;
            `VDMS_ADDR_RAW_GAIN: rdata_nxt = raw_path_gain_r;
            `VDMS_ADDR_RAW_OFS:  rdata_nxt = raw_path_offset_r;
            `VDMS_ADDR_STAT1:    rdata_nxt = decoder_status_first_r;
            `VDMS_ADDR_STAT2:    rdata_nxt = decoder_status_second_r;
            default:             rdata_nxt = 8'h00;
        endcase
    end

    // read data registered one cycle after strobe
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_nxt;
            end
        end
    end

    // ==========================================================
    // clock outputs and their three-state controls
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_div_r <= 2'h0;
        end else if (ce_i) begin
            clk_div_r <= clk_div_r + 2'h1;
        end
    end

    assign line_locked_clock_out_o = clk_div_r[0];
    assign half_rate_clock_out_o   = clk_div_r[1];
    assign line_clock_out_oe_n_o   = misc_clock_gate_msb_ctrl_r[`VDMS_MISC_LINE_TRI];
    assign half_clock_out_oe_n_o   = misc_clock_gate_msb_ctrl_r[`VDMS_MISC_HALF_TRI];

    // ==========================================================
    // standard detection search period in fields
    // a zero code would end the
    // search every field, so it acts as three
    // reserved code uses three
    assign search_latency_fields =
        (misc_clock_gate_msb_ctrl_r[`VDMS_MISC_LAT_HI:`VDMS_MISC_LAT_LO]
         == `VDMS_LAT_RESERVED) ? `VDMS_LAT_DEFAULT :
        misc_clock_gate_msb_ctrl_r[`VDMS_MISC_LAT_HI:`VDMS_MISC_LAT_LO];

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            field_cnt_r     <= 3'h0;
            search_period_o <= 1'b0;
        end else if (ce_i) begin
            search_period_o <= 1'b0;
            if (field_start_i) begin
                if (field_cnt_r + 3'h1 >= search_latency_fields) begin
                    field_cnt_r     <= 3'h0;
                    search_period_o <= 1'b1;
                end else begin
                    field_cnt_r <= field_cnt_r + 3'h1;
                end
            end
        end
    end

    // ==========================================================
    // nine-bit gate lines
    // msb bits join low bytes
    assign gate_start_line = {misc_clock_gate_msb_ctrl_r[`VDMS_MISC_START_MSB],
                              gate_start_low_i};
    assign gate_stop_line  = {misc_clock_gate_msb_ctrl_r[`VDMS_MISC_STOP_MSB],
                              gate_stop_low_i};

    vdms_gate_gen u_gate (
        .clock_i            (clock_i),
        .rst_n_i            (rst_n),
        .ce_i               (ce_i),
        .line_start_i       (line_start_i),
        .second_field_i     (second_field_i),
        .line_count_i       (line_count_i),
        .start_line_i       (gate_start_line),
        .stop_line_i        (gate_stop_line),
        .alt_pos_i          (misc_clock_gate_msb_ctrl_r[`VDMS_MISC_ALT_POS]),
        .vertical_gate_o    (vertical_gate_o),
        .field_identifier_o (field_identifier_o)
    );

    // ==========================================================
    // raw sample gain and offset
    // gain scaling
    assign raw_prod = raw_sample_i * raw_path_gain_r;
    assign raw_sum  = $signed({2'b00, raw_prod[15:`VDMS_GAIN_SHIFT]})
                    + $signed({4'h0, raw_path_offset_r})
                    - `VDMS_OFS_ZERO;

    // clamp to eight bits and register
    // unity gain is 0x40, so the
    // sum may pass either end
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            raw_sample_o <= 8'h00;
            raw_valid_o  <= 1'b0;
        end else if (ce_i) begin
            raw_valid_o <= raw_valid_i;
            if (raw_valid_i) begin
                if (raw_sum < 12'sh000) begin
                    raw_sample_o <= 8'h00;
                end else if (raw_sum > `VDMS_PIX_MAX) begin
                    raw_sample_o <= 8'hFF;
                end else begin
                    raw_sample_o <= raw_sum[7:0];
                end
            end
        end
    end

endmodule

// file: dv/vdms_regs_chk.sv
`timescale 1ns/1ps
`include "vdms_defines.svh"

module vdms_regs_chk (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    input wire logic       line_clock_out_oe_n_o,
    input wire logic       half_clock_out_oe_n_o,
    input wire logic       line_start_i,
    input wire logic       second_field_i,
    input wire logic [8:0] line_count_i,
    input wire logic [7:0] gate_start_low_i,
    input wire logic [7:0] gate_stop_low_i,
    input wire logic       vertical_gate_o,
    input wire logic       field_identifier_o,
    input wire logic       raw_valid_i,
    input wire logic       raw_valid_o,
    input wire logic       hloop_unlocked_i,
    input wire logic       vloop_unlocked_i,
    input wire logic       other_loops_locked_i,
    input wire logic       slow_constant_active_i,
    input wire logic       luma_gain_at_top_i,
    input wire logic       luma_gain_at_bottom_i,
    input wire logic       white_peak_active_i,
    input wire logic [1:0] colour_standard_found_i,
    input wire logic       interlace_seen_i,
    input wire logic       field_rate_sixty_i,
    input wire logic       stripe_four_line_seen_i,
    input wire logic       stripe_any_seen_i,
    input wire logic       protected_source_seen_i
);
    // ==========================================================
    // helper logic
    logic [7:0] misc_r;
    logic [4:0] st1_w;
    logic [1:0] loop_w;
    logic [4:0] st2_w;
    logic [8:0] start_adj;
    logic [8:0] stop_adj;

    // shadow copy of the misc register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            misc_r <= `VDMS_MISC_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == `VDMS_ADDR_MISC) begin
            misc_r <= reg_wdata_i;
        end
    end

    // expected status fields and gate lines
    assign st1_w = {hloop_unlocked_i, slow_constant_active_i, luma_gain_at_top_i,
                    luma_gain_at_bottom_i, white_peak_active_i};
    assign loop_w = {hloop_unlocked_i | vloop_unlocked_i,
                     ~(hloop_unlocked_i | vloop_unlocked_i) & other_loops_locked_i};
    assign st2_w = {interlace_seen_i, field_rate_sixty_i, stripe_four_line_seen_i,
                    stripe_any_seen_i | stripe_four_line_seen_i, protected_source_seen_i};
    assign start_adj = {misc_r[0], gate_start_low_i} - {8'h00, misc_r[2] & second_field_i};
    assign stop_adj = {misc_r[1], gate_stop_low_i} - {8'h00, misc_r[2] & second_field_i};

    // ==========================================================
    // properties
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence rd_take_s;
        ce_i && reg_rd_i;
    endsequence
    sequence rd_of_s(a);
        ce_i && $past(ce_i) && reg_rd_i && reg_addr_i == a;
    endsequence
    sequence start_hit_s;
        ce_i && line_start_i && line_count_i == start_adj;
    endsequence
    sequence stop_hit_s;
        ce_i && line_start_i && line_count_i == stop_adj && line_count_i != start_adj;
    endsequence

    rd_valid_a: assert property (rd_take_s |=> reg_rvalid_o)
        else $error("read valid missing");
    rd_pulse_a: assert property (rd_take_s ##1 (ce_i && !reg_rd_i) |=> !reg_rvalid_o)
        else $error("read valid too long");
    oe_update_a: assert property (ce_i && reg_wr_i && reg_addr_i == `VDMS_ADDR_MISC
        |=> {line_clock_out_oe_n_o, half_clock_out_oe_n_o} == $past(reg_wdata_i[7:6]))
        else $error("clock enable pins wrong");
    st1_colour_a: assert property (rd_of_s(`VDMS_ADDR_STAT1)
        |=> reg_rdata_o[1:0] == $past(colour_standard_found_i, 2) && !reg_rdata_o[7])
        else $error("colour standard wrong");
    st1_flags_a: assert property (rd_of_s(`VDMS_ADDR_STAT1)
        |=> reg_rdata_o[6:2] == $past(st1_w, 2))
        else $error("status one flags wrong");
    st2_loops_a: assert property (rd_of_s(`VDMS_ADDR_STAT2)
        |=> {reg_rdata_o[6], reg_rdata_o[0]} == $past(loop_w, 2))
        else $error("loop status wrong");
    st2_flags_a: assert property (rd_of_s(`VDMS_ADDR_STAT2)
        |=> {reg_rdata_o[7], reg_rdata_o[5], reg_rdata_o[3:1]} == $past(st2_w, 2))
        else $error("status two flags wrong");
    st2_reserved_a: assert property (rd_of_s(`VDMS_ADDR_STAT2) |=> !reg_rdata_o[4])
        else $error("status two bit 4 set");
    gate_rise_a: assert property (start_hit_s
        |=> vertical_gate_o && field_identifier_o != $past(field_identifier_o))
        else $error("gate start wrong");
    gate_fall_a: assert property (stop_hit_s |=> !vertical_gate_o)
        else $error("gate stop wrong");
    raw_valid_a: assert property (ce_i |=> raw_valid_o == $past(raw_valid_i))
        else $error("raw valid latency wrong");
endmodule

bind vdms_regs vdms_regs_chk u_chk (
    .clock_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .line_clock_out_oe_n_o, .half_clock_out_oe_n_o, .line_start_i,
    .second_field_i, .line_count_i, .gate_start_low_i, .gate_stop_low_i, .vertical_gate_o,
    .field_identifier_o, .raw_valid_i, .raw_valid_o, .hloop_unlocked_i, .vloop_unlocked_i,
    .other_loops_locked_i, .slow_constant_active_i, .luma_gain_at_top_i,
    .luma_gain_at_bottom_i, .white_peak_active_i, .colour_standard_found_i, .interlace_seen_i,
    .field_rate_sixty_i, .stripe_four_line_seen_i, .stripe_any_seen_i, .protected_source_seen_i
);

// file: dv/tb.sv
`timescale 1ns/1ps
`include "vdms_defines.svh"

module tb;
    logic        clk, rst_n, ce, wr_en, rd_en, rvalid, fstart, search;
    logic        lstart, second, vg, fld_id, raw_vi, raw_vo;
    logic        lclk, hclk, loe_n, hoe_n;
    logic [7:0]  addr, wdata, rdata, gs_low, gp_low, raw_in, raw_out;
    logic [13:0] st;
    logic [8:0]  lcount;
    int          n_fail, compares;

    // ==========================================================
    // device under test
    vdms_regs uut (
        .clock_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr_en),
        .reg_wdata_i(wdata), .reg_rd_i(rd_en), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .line_locked_clock_out_o(lclk), .line_clock_out_oe_n_o(loe_n),
        .half_rate_clock_out_o(hclk), .half_clock_out_oe_n_o(hoe_n),
        .field_start_i(fstart), .search_period_o(search), .line_start_i(lstart),
        .second_field_i(second), .line_count_i(lcount), .gate_start_low_i(gs_low),
        .gate_stop_low_i(gp_low), .vertical_gate_o(vg), .field_identifier_o(fld_id),
        .raw_sample_i(raw_in), .raw_valid_i(raw_vi), .raw_sample_o(raw_out),
        .raw_valid_o(raw_vo), .hloop_unlocked_i(st[0]), .vloop_unlocked_i(st[1]),
        .other_loops_locked_i(st[2]), .slow_constant_active_i(st[3]),
        .luma_gain_at_top_i(st[4]), .luma_gain_at_bottom_i(st[5]),
        .white_peak_active_i(st[6]), .colour_standard_found_i(st[8:7]),
        .interlace_seen_i(st[9]), .field_rate_sixty_i(st[10]),
        .stripe_four_line_seen_i(st[11]), .stripe_any_seen_i(st[12]),
        .protected_source_seen_i(st[13])
    );

    // clock and watchdog
    always #20 clk = ~clk;
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
    endtask
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // reset state
    task automatic t_reset();
        rdc(`VDMS_ADDR_MISC, 8'h18);
        rdc(`VDMS_ADDR_RAW_GAIN, 8'h40);
        rdc(`VDMS_ADDR_RAW_OFS, 8'h80);
        rdc(`VDMS_ADDR_STAT1, 8'h00);
        rdc(`VDMS_ADDR_STAT2, 8'h00);
        rdc(8'h20, 8'h00);
        check({6'h00, loe_n, hoe_n}, 8'h00);
    endtask
    task automatic t_regs();
        logic [7:0] v [4] = '{8'hC7, 8'h45, 8'h9A, 8'h18};
        for (int i = 0; i < 4; i++) begin
            wr(`VDMS_ADDR_MISC, v[i]);
            check({6'h00, loe_n, hoe_n}, {6'h00, v[i][7:6]});
            rdc(`VDMS_ADDR_MISC, v[i]);
        end
        wr(`VDMS_ADDR_RAW_GAIN, 8'h5A);
        rdc(`VDMS_ADDR_RAW_GAIN, 8'h5A);
        wr(`VDMS_ADDR_RAW_OFS, 8'hA5);
        rdc(`VDMS_ADDR_RAW_OFS, 8'hA5);
        wr(`VDMS_ADDR_STAT1, 8'hFF);
        rdc(`VDMS_ADDR_STAT1, 8'h00);
        wr(`VDMS_ADDR_STAT2, 8'hFF);
        rdc(`VDMS_ADDR_STAT2, 8'h00);
    endtask
    task automatic t_status();
        logic [13:0] v;
        logic        hv;
        for (int i = 0; i < 16; i++) begin
            v = (i < 14) ? 14'h0001 << i : ((i == 14) ? 14'h3FFF : 14'h0184);
            hv = v[0] | v[1];
            @(posedge clk);
            st <= v;
            repeat (2) @(posedge clk);
            rdc(`VDMS_ADDR_STAT1, {1'b0, v[0], v[3], v[4], v[5], v[6], v[8:7]});
            rdc(`VDMS_ADDR_STAT2, {v[9], hv, v[10], 1'b0, v[11], v[12] | v[11], v[13],
                                   ~hv & v[2]});
        end
    endtask
    task automatic t_latency();
        int cnt, first, en;
        for (int n = 1; n <= 8; n++) begin
            en = (n == 8) ? 3 : n;
            wr(`VDMS_ADDR_MISC, {2'b00, (n == 8) ? 3'h0 : 3'(n), 3'b000});
            cnt = 0;
            first = 0;
            for (int k = 1; k <= 2 * en; k++) begin
                @(posedge clk);
                fstart <= 1'b1;
                @(posedge clk);
                fstart <= 1'b0;
                repeat (3) begin
                    #1;
                    if (search === 1'b1) begin
                        cnt++;
                        if (first == 0) first = k;
                    end
                    @(posedge clk);
                end
            end
            check(8'(cnt), 8'h02);
            check(8'(first), 8'(en));
        end
    endtask
    // one line start, then gate level and identifier toggle
    task automatic step(input logic [8:0] n, input logic g, input logic tog);
        logic f0;
        f0 = fld_id;
        @(posedge clk);
        lcount <= n;
        lstart <= 1'b1;
        @(posedge clk);
        lstart <= 1'b0;
        #1;
        check({6'h00, vg, fld_id ^ f0}, {6'h00, g, tog});
    endtask
    task automatic t_gate();
        @(posedge clk);
        gs_low <= 8'h05;
        gp_low <= 8'h0A;
        wr(`VDMS_ADDR_MISC, 8'h1B);
        step(9'h10A, 1'b0, 1'b0);
        step(9'h005, 1'b0, 1'b0);
        step(9'h105, 1'b1, 1'b1);
        step(9'h106, 1'b1, 1'b0);
        step(9'h00A, 1'b1, 1'b0);
        step(9'h10A, 1'b0, 1'b0);
        wr(`VDMS_ADDR_MISC, 8'h1F);
        step(9'h104, 1'b0, 1'b0);
        @(posedge clk) second <= 1'b1;
        step(9'h105, 1'b0, 1'b0);
        step(9'h104, 1'b1, 1'b1);
        step(9'h109, 1'b0, 1'b0);
        @(posedge clk) second <= 1'b0;
    endtask
    task automatic t_raw();
        logic [31:0] tv [8] = '{32'h5A00FF7F, 32'h5A40805A, 32'h407F807F, 32'hFF7F80FF,
                                32'h90400010, 32'h20400000, 32'h1040FF8F, 32'h80208040};
        for (int i = 0; i < 8; i++) begin
            wr(`VDMS_ADDR_RAW_GAIN, tv[i][23:16]);
            wr(`VDMS_ADDR_RAW_OFS, tv[i][15:8]);
            @(posedge clk);
            raw_in <= tv[i][31:24];
            raw_vi <= 1'b1;
            @(posedge clk);
            raw_vi <= 1'b0;
            #1;
            check(raw_out, tv[i][7:0]);
            check({7'h00, raw_vo}, 8'h01);
        end
    endtask

    // clock outputs step, then hold while ce is low
    task automatic t_ce();
        logic [1:0] d;
        @(posedge clk);
        #1 d = {hclk, lclk} + 2'h1;
        @(posedge clk);
        ce <= 1'b0;
        wr(`VDMS_ADDR_MISC, 8'hC0);
        check({4'h0, hclk, lclk, loe_n, hoe_n}, {4'h0, d, 2'b00});
        @(posedge clk) ce <= 1'b1;
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        {wr_en, rd_en, fstart, lstart, second, raw_vi} = 6'h00;
        {addr, wdata, gs_low, gp_low, raw_in} = 40'h0;
        st = 14'h0000;
        lcount = 9'h000;
        n_fail = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_regs();
        t_status();
        t_latency();
        t_gate();
        t_raw();
        t_ce();
        wrap_up();
    end
endmodule
